// ### rtl/rwwsp_top.sv
// Self-programming controller with read-while-write regions
// Overview of operation
// - Boot-size fuses split application and boot regions
// - Each region has its own lock bit pair
// - Store from application region is ignored
// - Boot-issued store may target any address
// - Fixed read-while-write and no-read regions exist
// - Stall decision uses target page region only
// - Read-while-write target keeps core running
// - No-read target stalls CPU until operation ends
// - Read-while-write code invalid while programming
// - Boot region always lies in no-read region
// - Busy flag reads one while region blocked
// - Erase and write act on whole pages
// - Starting read-while-write erase or write sets busy
// - Re-enable write once the operation is over, or page load, clears busy
`timescale 1ns/100ps
module rwwsp_top (
  input  wire logic        i_ref_clk,   // System clock 200 MHz
  input  wire logic        i_rst_b,     // Async reset, active low
  input  wire logic [1:0]  i_bsz,       // Boot-size fuses
  input  wire logic [1:0]  i_blb_app,   // Application lock pair
  input  wire logic [1:0]  i_blb_boot,  // Boot-loader lock pair
  input  wire logic        i_store_vld, // Store instruction pulse
  input  wire logic [12:0] i_store_pc,  // Address of that instruction
  input  wire logic [12:0] i_fetch_adr, // Current code read address
  input  wire logic [15:0] i_fetch_dat, // Raw flash read data
  input  wire logic [2:0]  i_addr,      // Register address
  input  wire logic [7:0]  i_wdata,     // Register write data
  input  wire logic        i_wr,        // Register write strobe
  input  wire logic        i_rd,        // Register read strobe
  output logic [7:0]       o_rdata,     // Read data, cycle after strobe
  output logic             o_cpu_halt,  // Stall the core
  output logic             o_code_vld,  // Fetch data valid
  output logic [15:0]      o_code_dat,  // Fetch data to core
  output logic             o_pg_erase,  // Page erase start pulse
  output logic             o_pg_write,  // Page write start pulse
  output logic             o_pg_load,   // Page buffer load pulse
  output logic [12:0]      o_pg_adr     // Page-aligned target address
);
  ////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_m_q;                        // First reset stage
  logic rst_b;                          // Synchronised reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m_q <= 1'b0;
      rst_b   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_b   <= rst_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Region decode of issuer, target and fetch
  rwwsp_pkg::rwwsp_req_t req;           // Bundled store request
  logic [12:0] tgt_q;                   // Target address register
  logic [12:0] tgt_d;
  logic        pc_boot;                 // Issued from boot region
  logic        tgt_boot;                // Target in boot region
  logic        tgt_nord;                // Target in no-read region
  logic        fch_nord;                // Fetch in no-read region
  assign req.valid = i_store_vld;
  assign req.pc    = i_store_pc;

  rwwsp_region u_pc (
    .i_addr (req.pc),
    .i_bsz  (i_bsz),
    .o_boot (pc_boot),
    .o_nord ()
  );
  rwwsp_region u_tgt (
    .i_addr (tgt_q),
    .i_bsz  (i_bsz),
    .o_boot (tgt_boot),
    .o_nord (tgt_nord)
  );
  rwwsp_region u_fch (
    .i_addr (i_fetch_adr),
    .i_bsz  (i_bsz),
    .o_boot (),
    .o_nord (fch_nord)
  );

  ////////////////////////////////////////////////////////////////////
  // Control state
  typedef enum logic [2:0] {
    RWWSP_IDLE = 3'b001,
    RWWSP_RUN  = 3'b010,                // Rdwr-region op, core runs
    RWWSP_HALT = 3'b100                 // No-read op, core stalled
  } rwwsp_st_t;
  rwwsp_st_t  st_q;
  rwwsp_st_t  st_d;
  logic [2:0] cmd_q;                    // Armed command bits
  logic [2:0] cmd_d;
  logic       busy_q;                   // Region busy flag
  logic       busy_d;
  logic       lockf_q;                  // Last erase/write store refused by lock
  logic       lockf_d;
  logic       start;                    // Erase or write launch
  logic       tmr_busy;
  logic       tmr_done;
  logic       allow;                    // Lock permits the store
  logic       go;                       // Accepted store instruction

  // Lock pair of the target region decides write permission
  function automatic logic lock_ok(input logic [1:0] p);
    lock_ok = (p == rwwsp_pkg::BLB_FREE) || (p == 2'h1);
  endfunction

  always_comb begin
    allow = tgt_boot ? lock_ok(i_blb_boot)
                     : lock_ok(i_blb_app);
    // Store only counts from boot code; target may be anywhere
    go    = req.valid && pc_boot && (st_q == RWWSP_IDLE);
  end

  rwwsp_timer u_tmr (
    .i_clk   (i_ref_clk),
    .i_rst_b (rst_b),
    .i_start (start),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  // Next state for sequencing, flags and registers
  always_comb begin
    st_d    = st_q;
    cmd_d   = cmd_q;
    busy_d  = busy_q;
    lockf_d = lockf_q;
    tgt_d   = tgt_q;
    start   = 1'b0;
    if (i_wr && (i_addr == rwwsp_pkg::REG_ALO)) begin
      tgt_d[7:0] = i_wdata;
    end
    if (i_wr && (i_addr == rwwsp_pkg::REG_AHI)) begin
      tgt_d[12:8] = i_wdata[4:0];
    end
    if (i_wr && (i_addr == rwwsp_pkg::REG_CTRL)) begin
      cmd_d = i_wdata[2:0];
      // Re-enable clears busy only once the operation is over
      if (i_wdata[rwwsp_pkg::B_REEN] && (st_q == RWWSP_IDLE)) begin
        busy_d = 1'b0;
      end
    end
    case (st_q)
      RWWSP_IDLE: begin
        if (go) begin
          cmd_d = 3'h0;
          if (cmd_q[rwwsp_pkg::B_LOAD]) begin
            busy_d = 1'b0;
          end else if (cmd_q[rwwsp_pkg::B_ERASE] ||
                       cmd_q[rwwsp_pkg::B_WRITE]) begin
            lockf_d = !allow;
            if (allow) begin
              start = 1'b1;
              // Only the target's fixed region picks the mode
              st_d  = tgt_nord ? RWWSP_HALT : RWWSP_RUN;
              // Busy set on rdwr launch; wins over same-cycle clear
              if (!tgt_nord) begin
                busy_d = 1'b1;
              end
            end
          end
        end
      end
      RWWSP_RUN, RWWSP_HALT: begin
        if (tmr_done) begin
          st_d = RWWSP_IDLE;
        end
      end
      default: st_d = RWWSP_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= RWWSP_IDLE;
      cmd_q   <= 3'h0;
      busy_q  <= 1'b0;
      lockf_q <= 1'b0;
      tgt_q   <= 13'h0000;
    end else begin
      st_q    <= st_d;
      cmd_q   <= cmd_d;
      busy_q  <= busy_d;
      lockf_q <= lockf_d;
      tgt_q   <= tgt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [7:0]  rdata_d;
  logic        halt_d;
  logic        cvld_d;
  logic [15:0] cdat_d;
  logic [12:0] padr_d;

  always_comb begin
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        rwwsp_pkg::REG_CTRL: begin
          rdata_d[2:0]               = cmd_q;
          rdata_d[rwwsp_pkg::B_BUSY]  = busy_q;
          rdata_d[rwwsp_pkg::B_LOCKF] = lockf_q;
        end
        rwwsp_pkg::REG_ALO: rdata_d = tgt_q[7:0];
        rwwsp_pkg::REG_AHI: rdata_d = {3'h0, tgt_q[12:8]};
        default:            rdata_d = 8'h00;
      endcase
    end
    // Stall through the whole no-read op, from the cycle after launch
    halt_d = (st_d == RWWSP_HALT);
    // No-read code stays readable; rdwr code blanked while busy
    cvld_d = fch_nord || !busy_d;
    cdat_d = cvld_d ? i_fetch_dat : 16'h0000;
    // Page granularity: low offset bits dropped for erase/write
    padr_d = {tgt_q[12:rwwsp_pkg::PAGE_LSB],
              {rwwsp_pkg::PAGE_LSB{1'b0}}};
  end

  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_rdata    <= 8'h00;
      o_cpu_halt <= 1'b0;
      o_code_vld <= 1'b0;
      o_code_dat <= 16'h0000;
      o_pg_erase <= 1'b0;
      o_pg_write <= 1'b0;
      o_pg_load  <= 1'b0;
      o_pg_adr   <= 13'h0000;
    end else begin
      o_rdata    <= rdata_d;
      o_cpu_halt <= halt_d;
      o_code_vld <= cvld_d;
      o_code_dat <= cdat_d;
      o_pg_erase <= start && cmd_q[rwwsp_pkg::B_ERASE];
      o_pg_write <= start && !cmd_q[rwwsp_pkg::B_ERASE];
      o_pg_load  <= go && cmd_q[rwwsp_pkg::B_LOAD];
      o_pg_adr   <= padr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_app_store_ign: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (i_store_vld && !pc_boot) |=> !o_pg_erase && !o_pg_write)
    else $error("store from application region started an operation");
  a_busy_on_launch: assert property (@(posedge i_ref_clk)
    disable iff (!rst_b)
    (start && !tgt_nord) |=> busy_q)
    else $error("busy not set on read-while-write launch");
  a_halt_nord: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (start && tgt_nord) |=> o_cpu_halt)
    else $error("core not halted for no-read operation");
  a_run_on_rdwr: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (start && !tgt_nord) |=> !o_cpu_halt)
    else $error("core halted for read-while-write operation");
  a_halt_ends: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (o_cpu_halt && tmr_done) |=> !o_cpu_halt)
    else $error("halt not released after operation");
  a_blank_busy: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (busy_d && !fch_nord) |=> !o_code_vld)
    else $error("blocked region code returned while busy");
  // The timer must run for as long as the sequencer is not idle
  a_op_timed: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (st_q != RWWSP_IDLE) |-> (tmr_busy || tmr_done))
    else $error("operation active without running timer");
  a_busy_read: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (i_rd && i_addr == rwwsp_pkg::REG_CTRL)
      |=> o_rdata[rwwsp_pkg::B_BUSY] == $past(busy_q))
    else $error("busy flag read wrong");
  a_load_clear: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (go && cmd_q[rwwsp_pkg::B_LOAD]) |=> !busy_q ##0 o_pg_load)
    else $error("page load did not clear busy");
endmodule // rwwsp_top

// ### rtl/rwwsp_pkg.sv
// Package with constants and types for the self-program controller
package rwwsp_pkg;
  localparam int unsigned ADDR_W    = 13;            // Byte address width
  localparam int unsigned PAGE_LSB  = 6;             // Page offset bits
  localparam logic [12:0] NRD_BASE  = 13'h1800;      // Fixed region limit
  localparam int unsigned OP_NS     = 4000;          // Erase/write time ns
  localparam int unsigned CLK_MHZ   = 200;           // System clock rate
  localparam int unsigned OP_CYC    = (OP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W     = 16;            // Op counter width
  localparam logic [2:0]  REG_CTRL  = 3'h0;          // Control/status reg
  localparam logic [2:0]  REG_ALO   = 3'h1;          // Target address low
  localparam logic [2:0]  REG_AHI   = 3'h2;          // Target address high
  localparam int unsigned B_REEN    = 4;             // Re-enable bit
  localparam int unsigned B_BUSY    = 6;             // Busy flag bit
  localparam int unsigned B_LOCKF   = 5;             // Last op refused
  localparam int unsigned B_LOAD    = 0;             // Page load flag
  localparam int unsigned B_ERASE   = 1;             // Page erase flag
  localparam int unsigned B_WRITE   = 2;             // Page write flag
  localparam logic [1:0]  BLB_FREE  = 2'h3;          // Lock pair: no limit
  localparam logic [1:0]  BLB_NOWR  = 2'h2;          // Lock pair: no store

  // Store instruction request from the core
  typedef struct packed {
    logic              valid;                        // One-cycle request
    logic [ADDR_W-1:0] pc;                           // Issuing fetch addr
  } rwwsp_req_t;

  // Boot-size fuse codes
  typedef enum logic [1:0] {
    RWWSP_BOOT_2K  = 2'h0,
    RWWSP_BOOT_1K  = 2'h1,
    RWWSP_BOOT_512 = 2'h2,
    RWWSP_BOOT_256 = 2'h3
  } rwwsp_bsz_t;
endpackage

// ### rtl/rwwsp_region.sv
// Region decoder: boot/application and fixed no-read region
`timescale 1ns/100ps
module rwwsp_region (
  input  wire logic [12:0] i_addr,   // Byte address to classify
  input  wire logic [1:0]  i_bsz,    // Boot-size fuses
  output logic             o_boot,   // Address in boot-loader region
  output logic             o_nord    // Address in no-read region
);
  // Boot start per fuse; every choice lies at or above the fixed limit
  function automatic logic [12:0] boot_base(input logic [1:0] b);
    case (rwwsp_pkg::rwwsp_bsz_t'(b))
      rwwsp_pkg::RWWSP_BOOT_2K:  boot_base = 13'h1800;
      rwwsp_pkg::RWWSP_BOOT_1K:  boot_base = 13'h1c00;
      rwwsp_pkg::RWWSP_BOOT_512: boot_base = 13'h1e00;
      default:                   boot_base = 13'h1f00;
    endcase
  endfunction

  always_comb begin
    o_boot = (i_addr >= boot_base(i_bsz));
    o_nord = (i_addr >= rwwsp_pkg::NRD_BASE);
  end
endmodule // rwwsp_region

// ### rtl/rwwsp_timer.sv
// Operation timer for page erase and page write
`timescale 1ns/100ps
module rwwsp_timer (
  input  wire logic i_clk,    // System clock
  input  wire logic i_rst_b,  // Synchronised reset, active low
  input  wire logic i_start,  // Start one page operation
  output logic      o_busy,   // Operation in progress
  output logic      o_done    // One-cycle pulse at completion
);
  logic [15:0] cnt_q;         // Remaining cycles
  logic [15:0] cnt_d;
  logic        done_q;
  logic        done_d;

  // Count down the page operation time
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (i_start) begin
      cnt_d = 16'(rwwsp_pkg::OP_CYC);
    end else if (cnt_q != 16'h0000) begin
      cnt_d  = cnt_q - 16'h0001;
      done_d = (cnt_q == 16'h0001);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q  <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_busy = (cnt_q != 16'h0000);
  assign o_done = done_q;
endmodule // rwwsp_timer

// ### dv/rwwsp_core_model.sv
// Core model: issues store pulses and fetches code
`timescale 1ns/100ps
module rwwsp_core_model (
  input  wire logic        i_ref_clk,  // System clock
  input  wire logic        i_rst_b,    // Reset, active low
  input  wire logic        i_halt,     // Stall from controller
  input  wire logic        i_go,       // Bench asks for a store
  input  wire logic [12:0] i_pc,       // Where the store executes
  input  wire logic [12:0] i_base,     // Fetch window start
  output logic             o_store_vld, // Store pulse
  output logic [12:0]      o_store_pc, // Address of that store
  output logic [12:0]      o_fetch_adr // Fetch address
);
  logic [3:0] ofs_q;  // Offset within fetch window

  // Store lasts one cycle; fetching freezes while stalled
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_store_vld <= 1'b0;
      o_store_pc  <= 13'h0000;
      ofs_q     <= 4'h0;
    end else begin
      o_store_vld <= i_go;
      // Stale pc is scrambled so the controller cannot lean on it
      o_store_pc  <= i_go ? i_pc : ~o_store_pc;
      if (!i_halt) begin
        ofs_q <= ofs_q + 4'h1;
      end
    end
  end

  // The bench keeps the window off busy pages except on purpose
  assign o_fetch_adr = i_base + {9'h000, ofs_q};
endmodule // rwwsp_core_model

// ### dv/rwwsp_top_tb.sv
// Testbench for the self-program controller
`timescale 1ns/100ps
module rwwsp_top_tb;
  logic        ref_clk = 1'b0;    // 200 MHz clock
  logic        rst_b   = 1'b0;    // Reset, active low
  logic [1:0]  bsz     = 2'h0;    // Boot-size fuses
  logic [1:0]  blb_a   = 2'h3;    // Application lock pair
  logic [1:0]  blb_b   = 2'h3;    // Boot lock pair
  logic        go      = 1'b0;    // Store request to model
  logic [12:0] go_pc   = 13'h0;   // Pc of that store
  logic [12:0] base    = 13'h1900;// Fetch window
  logic [2:0]  addr    = 3'h0;    // Register address
  logic [7:0]  wdata   = 8'h00;   // Register write data
  logic        wr      = 1'b0;    // Write strobe
  logic        rd      = 1'b0;    // Read strobe
  logic [12:0] exp_pg  = 13'h0;   // Expected page address
  logic [12:0] prev_a  = 13'h0;   // Fetch address a cycle ago
  logic        st_vld, halt, code_vld, pg_er, pg_wr, pg_ld;
  logic [12:0] st_pc, fetch_adr, pg_adr;
  logic [7:0]  rdata;
  logic [15:0] code_dat, fetch_dat;
  int          err_count, checks, n_er, n_wr, n_ld, n_halt, cyc_n;
  logic [12:0] boot [4] = '{13'h1800, 13'h1c00, 13'h1e00, 13'h1f00};

  always #2.5 ref_clk = ~ref_clk;
  assign fetch_dat = {3'h0, fetch_adr} ^ 16'ha5a5;

  rwwsp_core_model u_rwwsp_core_model (.i_ref_clk(ref_clk),
    .i_rst_b(rst_b), .i_halt(halt), .i_go(go), .i_pc(go_pc),
    .i_base(base), .o_store_vld(st_vld), .o_store_pc(st_pc),
    .o_fetch_adr(fetch_adr));
  rwwsp_top u_rwwsp_top (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
    .i_bsz(bsz), .i_blb_app(blb_a), .i_blb_boot(blb_b),
    .i_store_vld(st_vld), .i_store_pc(st_pc), .i_fetch_adr(fetch_adr),
    .i_fetch_dat(fetch_dat), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_cpu_halt(halt),
    .o_code_vld(code_vld), .o_code_dat(code_dat), .o_pg_erase(pg_er),
    .o_pg_write(pg_wr), .o_pg_load(pg_ld), .o_pg_adr(pg_adr));

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Monitor: pulse and stall counts, fetch data, hang limit
  always @(posedge ref_clk) begin
    cyc_n++;
    n_er += int'(pg_er === 1'b1);
    n_wr += int'(pg_wr === 1'b1);
    n_ld += int'(pg_ld === 1'b1);
    n_halt += int'(halt === 1'b1);
    if (code_vld === 1'b1) chk("code_dat", {3'h0, prev_a} ^ 16'ha5a5,
                               code_dat);
    if (pg_er === 1'b1 || pg_wr === 1'b1) chk("pg_adr", {3'h0, exp_pg},
                               {3'h0, pg_adr});
    prev_a = fetch_adr;
    if (cyc_n == 15000) begin
      err_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port and store helpers, entered just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    // Let one edge pass so a following write never re-raises wr here
    @(posedge ref_clk);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] m, input logic [7:0] e);
    addr <= rwwsp_pkg::REG_CTRL;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk("ctrl", {8'h00, e}, {8'h00, rdata & m});
    @(posedge ref_clk);
  endtask

  // Fetch window moved, then fetch validity sampled
  task automatic look(input logic [12:0] b, input logic e);
    base <= b;
    cyc(3);
    #1 chk("code_vld", {15'h0, e}, {15'h0, code_vld});
    @(posedge ref_clk);
  endtask

  // Command, target, store; pulses counted; stall length judged
  task automatic op(input logic [7:0] c, input logic [12:0] t,
                    input logic [12:0] pc, input int e, w, l, h);
    int b0, b1, b2, bh;
    wr_reg(rwwsp_pkg::REG_CTRL, c);
    wr_reg(rwwsp_pkg::REG_ALO, t[7:0]);
    wr_reg(rwwsp_pkg::REG_AHI, {3'h0, t[12:8]});
    exp_pg = {t[12:6], 6'h00};
    b0 = n_er;
    b1 = n_wr;
    b2 = n_ld;
    bh = n_halt;
    go_pc <= pc;
    go    <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    cyc(4);
    chk("erase_pulses", 16'(e), 16'(n_er - b0));
    chk("write_pulses", 16'(w), 16'(n_wr - b1));
    chk("load_pulses", 16'(l), 16'(n_ld - b2));
    for (int k = 0; k < 900 && halt !== 1'b0; k++) @(posedge ref_clk);
    bh = n_halt - bh;
    // One when the stall span matches: full op length, or none at all
    chk("halt_span", 16'h0001, 16'((h != 0 && bh >= rwwsp_pkg::OP_CYC &&
        bh <= rwwsp_pkg::OP_CYC + 2) || (h == 0 && bh == 0)));
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    checks    = 0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(3);
    rd_reg(8'hff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bsz <= i[1:0];
      op(8'h01, 13'h0040, boot[i] - 13'h1, 0, 0, 0, 0);
      op(8'h02, boot[i], boot[i], 1, 0, 0, 1);
      look(13'h1900, 1'b1);
    end
    bsz <= 2'h0;
    op(8'h02, 13'h0045, 13'h1800, 1, 0, 0, 0);
    rd_reg(8'h40, 8'h40);
    look(13'h1900, 1'b1);
    look(13'h0100, 1'b0);
    look(13'h1900, 1'b1);
    wr_reg(rwwsp_pkg::REG_CTRL, 8'h10);
    rd_reg(8'h40, 8'h40);
    cyc(rwwsp_pkg::OP_CYC);
    rd_reg(8'h40, 8'h40);
    wr_reg(rwwsp_pkg::REG_CTRL, 8'h10);
    rd_reg(8'h40, 8'h00);
    look(13'h0100, 1'b1);
    base <= 13'h1900;
    op(8'h04, 13'h0080, 13'h1a00, 0, 1, 0, 0);
    rd_reg(8'h40, 8'h40);
    cyc(rwwsp_pkg::OP_CYC);
    op(8'h01, 13'h0080, 13'h1a00, 0, 0, 1, 0);
    rd_reg(8'h40, 8'h00);
    blb_a <= rwwsp_pkg::BLB_NOWR;
    op(8'h02, 13'h0040, 13'h1800, 0, 0, 0, 0);
    rd_reg(8'h20, 8'h20);
    op(8'h04, 13'h1f80, 13'h1800, 0, 1, 0, 1);
    final_report();
  end
endmodule // rwwsp_top_tb
